/* File: acc_ref_consts.vh */
// constants for the accumulator-reference execution block
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - class when bits 16..12 are 11100 and bit 2 is 0; bits 7..3 pick op
// - swap bit 1 exchanges accumulator and offset accumulator as source
// - single-operand ops other than negate and invert read the offset accumulator when swap is set
// - two-operand ops with swap set reverse operand order of subtraction
// - negate and invert use reversed swap: set picks accumulator, clear picks offset
// - bit 0 clear writes the accumulator, set writes the offset accumulator
// - string execution supported; one of four pointers premodified before use
// - op 00000 writes two's complement of source, updates status
// - op 00001 writes one's complement of source, updates status
// - op 00010 loads program word at source address, post-increments data pointer
// - op 00011 clears destination, updates status
// - op 00100 subtracts offset from accumulator, or reverse with swap set
// - op 00101 adds accumulator and offset accumulator, updates status
// - op 00110 shifts left one, zero into lsb, msb into carry
// - op 00111 copies source to destination, updates status
// - marked ops run one word in string mode, chaining previous carry and zero
`ifndef ACC_REF_CONSTS_VH
`define ACC_REF_CONSTS_VH
// ****************************************************************
// instruction decode
// ****************************************************************
`define CLS_TOP 5'h1C
`define OP_NEG 5'h00
`define OP_NOT 5'h01
`define OP_LOOK 5'h02
`define OP_ZERO 5'h03
`define OP_SUB 5'h04
`define OP_ADD 5'h05
`define OP_SHL 5'h06
`define OP_MOV 5'h07
`define PM_INC 2'h1
`define PM_DEC 2'h2
`define OFS_BIT 5'h10
// ****************************************************************
// register map and reset values
// ****************************************************************
`define REG_STRCNT 8'h00
`define REG_SWMASK 8'h01
`define REG_PTR0 8'h04
`define REG_STATUS 8'h08
`define REG_DPTR 8'h09
`define REG_ACC0 8'h20
`define ST_CF 0
`define ST_ZF 1
`define ST_SF 2
`define ST_OF 3
`define ST_BUSY 4
`define STRCNT_RST 8'h00
`define SWMASK_RST 8'h00
`define DPTR_RST 16'h0000
`define PTR_RST 5'h00
`endif

/* File: acc_ref_exec.v */
// accumulator-reference instruction decoder and executor
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "acc_ref_consts.vh"

module acc_ref_exec
#(
  parameter DW = 16,
  parameter NPTR = 4
)
(
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // instruction issue
  input wire instr_valid_i,
  input wire [16:0] instr_i,
  input wire instr_string_i,
  output wire instr_ready_o,
  output wire done_o,
  output wire illegal_o,
  // program memory lookup
  output wire pm_rd_o,
  output wire [DW-1:0] pm_addr_o,
  input wire [DW-1:0] pm_data_i,
  // status
  output wire carry_o,
  output wire zero_o,
  output wire sign_o,
  output wire ovf_o,
  output wire [DW-1:0] data_pointer_reg_o,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [DW-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [DW-1:0] reg_rdata_o
);

  // ****************************************************************
  // states and decode helpers
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_EXEC = 3'd1;
  localparam [2:0] S_LK_ISSUE = 3'd2;
  localparam [2:0] S_LK_WAIT = 3'd3;
  localparam [2:0] S_LK_CAP = 3'd4;

  function is_class;
    input [16:0] w;
    begin
      is_class = (w[16:12] == `CLS_TOP) && (w[2] == 1'b0);
    end
  endfunction

  function [4:0] premod;
    input [4:0] p;
    input [1:0] how;
    begin
      case (how)
        `PM_INC: premod = p + 5'h01;
        `PM_DEC: premod = p - 5'h01;
        default: premod = p;
      endcase
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg [2:0] state_r;
  reg [4:0] op_r;
  reg swap_r;
  reg dst_r;
  reg single_r;
  reg [4:0] base_r;
  reg [8:0] word_r;
  reg [8:0] nwords_r;
  reg ready_r;
  reg done_r;
  reg illegal_r;
  reg pm_rd_r;
  reg [DW-1:0] pm_addr_r;
  reg cf_r;
  reg zf_r;
  reg sf_r;
  reg of_r;
  reg [DW-1:0] dptr_r;
  reg [7:0] strcnt_r;
  reg [7:0] swmask_r;
  reg [DW-1:0] rdata_r;
  // accumulator file has no reset; software loads it before use
  reg [DW-1:0] acc_mem [0:31];
  wire [4:0] ptr_w [0:NPTR-1];
  wire accept = instr_valid_i & ready_r;
  wire legal = is_class(instr_i) & (instr_i[7:3] <= `OP_MOV);
  wire [1:0] psel = instr_i[9:8];
  wire [4:0] ptr_new = premod(ptr_w[psel], instr_i[11:10]);
  wire sw_acc_wr = reg_wr_i & ready_r & (reg_addr_i[7:5] == 3'h1);
  // writes are only honoured while idle so an op sees stable operands
  wire sw_wr_status = reg_wr_i & ready_r & (reg_addr_i == `REG_STATUS);
  wire sw_wr_dptr = reg_wr_i & ready_r & (reg_addr_i == `REG_DPTR);

  // ****************************************************************
  // pointer registers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NPTR; gi = gi + 1)
    begin : gen_ptr
      reg [4:0] p_r;
      always @(posedge ref_clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          p_r <= `PTR_RST;
        else if (accept && legal && psel == gi)
          p_r <= ptr_new;
        else if (reg_wr_i && ready_r && reg_addr_i == `REG_PTR0 + gi)
          p_r <= reg_wdata_i[4:0];
      end
      assign ptr_w[gi] = p_r;
    end
  endgenerate

  // ****************************************************************
  // datapath for one word
  // ****************************************************************
  wire [4:0] idx = base_r + word_r[4:0];
  wire [4:0] oidx = idx ^ `OFS_BIT;
  wire [DW-1:0] av = acc_mem[idx];
  wire [DW-1:0] ov = acc_mem[oidx];
  wire inv_sel = (op_r == `OP_NEG) | (op_r == `OP_NOT);
  wire sel_off = swap_r ^ inv_sel;
  wire [DW-1:0] src = sel_off ? ov : av;
  wire [DW-1:0] xop = swap_r ? ov : av;
  wire [DW-1:0] yop = swap_r ? av : ov;
  // later words of a string, or a chained single word, carry on from last flags
  wire first = (word_r == 9'd0) & ~single_r;
  wire [4:0] dest = dst_r ? oidx : idx;

  reg [DW:0] wide;
  reg [DW-1:0] res;
  reg c_nxt;
  reg o_nxt;
  reg z_nxt;
  always @*
  begin
    wide = {(DW+1){1'b0}};
    res = {DW{1'b0}};
    c_nxt = 1'b0;
    o_nxt = 1'b0;
    case (op_r)
      `OP_NEG:
      begin
        wide = {1'b0, {DW{1'b0}}} + {1'b0, ~src} + {{DW{1'b0}}, (first ? 1'b1 : cf_r)};
        res = wide[DW-1:0];
        c_nxt = wide[DW];
        o_nxt = src[DW-1] & res[DW-1];
      end
      `OP_NOT:
      begin
        res = ~src;
      end
      `OP_ZERO:
      begin
        res = {DW{1'b0}};
      end
      `OP_SUB:
      begin
        wide = {1'b0, xop} + {1'b0, ~yop} + {{DW{1'b0}}, (first ? 1'b1 : cf_r)};
        res = wide[DW-1:0];
        c_nxt = wide[DW];
        o_nxt = (xop[DW-1] ^ yop[DW-1]) & (res[DW-1] ^ xop[DW-1]);
      end
      `OP_ADD:
      begin
        wide = {1'b0, av} + {1'b0, ov} + {{DW{1'b0}}, (first ? 1'b0 : cf_r)};
        res = wide[DW-1:0];
        c_nxt = wide[DW];
        o_nxt = ~(av[DW-1] ^ ov[DW-1]) & (res[DW-1] ^ av[DW-1]);
      end
      `OP_SHL:
      begin
        res = {src[DW-2:0], (first ? 1'b0 : cf_r)};
        c_nxt = src[DW-1];
      end
      `OP_LOOK:
      begin
        res = pm_data_i;
      end
      default:
      begin
        res = src;
      end
    endcase
    z_nxt = (res == {DW{1'b0}}) & (first ? 1'b1 : zf_r);
  end

  wire last = (word_r + 9'd1 == nwords_r);
  wire wr_word = (state_r == S_EXEC) | (state_r == S_LK_CAP);

  // ****************************************************************
  // accumulator file
  // ****************************************************************
  always @(posedge ref_clk_i)
  begin
    if (wr_word)
      acc_mem[dest] <= res;
    else if (sw_acc_wr)
      acc_mem[reg_addr_i[4:0]] <= reg_wdata_i;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= S_IDLE;
      op_r <= `OP_NEG;
      swap_r <= 1'b0;
      dst_r <= 1'b0;
      single_r <= 1'b0;
      base_r <= 5'h00;
      word_r <= 9'd0;
      nwords_r <= 9'd1;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      pm_rd_r <= 1'b0;
      pm_addr_r <= {DW{1'b0}};
      cf_r <= 1'b0;
      zf_r <= 1'b0;
      sf_r <= 1'b0;
      of_r <= 1'b0;
      dptr_r <= `DPTR_RST;
    end
    else
    begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      pm_rd_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (accept && !legal)
            illegal_r <= 1'b1;
          else if (accept)
          begin
            op_r <= instr_i[7:3];
            swap_r <= instr_i[1];
            dst_r <= instr_i[0];
            base_r <= ptr_new;
            word_r <= 9'd0;
            ready_r <= 1'b0;
            // marked ops ignore the string count and chain from the last op
            single_r <= instr_string_i & swmask_r[instr_i[5:3]];
            if (instr_string_i && !swmask_r[instr_i[5:3]])
              nwords_r <= {1'b0, strcnt_r} + 9'd2;
            else
              nwords_r <= 9'd1;
            state_r <= (instr_i[7:3] == `OP_LOOK) ? S_LK_ISSUE : S_EXEC;
          end
          else if (sw_wr_status)
          begin
            cf_r <= reg_wdata_i[`ST_CF];
            zf_r <= reg_wdata_i[`ST_ZF];
            sf_r <= reg_wdata_i[`ST_SF];
            of_r <= reg_wdata_i[`ST_OF];
          end
          else if (sw_wr_dptr)
            dptr_r <= reg_wdata_i;
        end
        S_LK_ISSUE:
        begin
          pm_rd_r <= 1'b1;
          pm_addr_r <= first ? src : dptr_r;
          state_r <= S_LK_WAIT;
        end
        S_LK_WAIT:
          state_r <= S_LK_CAP;
        default:
        begin
          cf_r <= c_nxt;
          zf_r <= z_nxt;
          sf_r <= res[DW-1];
          of_r <= o_nxt;
          if (state_r == S_LK_CAP)
            dptr_r <= pm_addr_r + {{(DW-1){1'b0}}, 1'b1};
          if (last)
          begin
            state_r <= S_IDLE;
            ready_r <= 1'b1;
            done_r <= 1'b1;
          end
          else
          begin
            word_r <= word_r + 9'd1;
            state_r <= (state_r == S_LK_CAP) ? S_LK_ISSUE : S_EXEC;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  always @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      strcnt_r <= `STRCNT_RST;
      swmask_r <= `SWMASK_RST;
    end
    else if (reg_wr_i && ready_r)
    begin
      if (reg_addr_i == `REG_STRCNT)
        strcnt_r <= reg_wdata_i[7:0];
      if (reg_addr_i == `REG_SWMASK)
        swmask_r <= reg_wdata_i[7:0];
    end
  end

  reg [DW-1:0] rd_mux;
  always @*
  begin
    rd_mux = {DW{1'b0}};
    if (reg_addr_i[7:5] == 3'h1)
      rd_mux = acc_mem[reg_addr_i[4:0]];
    else if (reg_addr_i == `REG_STRCNT)
      rd_mux = {8'h00, strcnt_r};
    else if (reg_addr_i == `REG_SWMASK)
      rd_mux = {8'h00, swmask_r};
    else if (reg_addr_i[7:2] == 6'h01)
      rd_mux = {11'h000, ptr_w[reg_addr_i[1:0]]};
    else if (reg_addr_i == `REG_STATUS)
      rd_mux = {11'h000, ~ready_r, of_r, sf_r, zf_r, cf_r};
    else if (reg_addr_i == `REG_DPTR)
      rd_mux = dptr_r;
  end

  always @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdata_r <= {DW{1'b0}};
    else if (reg_rd_i)
      rdata_r <= rd_mux;
    else
      rdata_r <= {DW{1'b0}};
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign instr_ready_o = ready_r;
  assign done_o = done_r;
  assign illegal_o = illegal_r;
  assign pm_rd_o = pm_rd_r;
  assign pm_addr_o = pm_addr_r;
  assign carry_o = cf_r;
  assign zero_o = zf_r;
  assign sign_o = sf_r;
  assign ovf_o = of_r;
  assign data_pointer_reg_o = dptr_r;
  assign reg_rdata_o = rdata_r;

endmodule // acc_ref_exec

/* File: acc_ref_checker.sv */
// assertion checker for the accumulator-reference executor
`timescale 1ns/1ps
module acc_ref_checker
#(
  parameter DW = 16
)
(
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // instruction issue
  input wire instr_valid_i,
  input wire [16:0] instr_i,
  input wire instr_string_i,
  input wire instr_ready_o,
  input wire done_o,
  input wire illegal_o,
  // lookup and status
  input wire pm_rd_o,
  input wire [DW-1:0] pm_addr_o,
  input wire carry_o,
  input wire zero_o,
  input wire [DW-1:0] data_pointer_reg_o,
  // register port
  input wire reg_rd_i,
  input wire [DW-1:0] reg_rdata_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire take = instr_valid_i && instr_ready_o;
  wire legal = instr_i[16:12] == 5'h1C && !instr_i[2] && instr_i[7:3] < 5'h08;
  wire [4:0] op = instr_i[7:3];
  // ****************************************
  // assertions
  // ****************************************
  bad_word_a: assert property (take && !legal |=> illegal_o)
    else $error("foreign word not flagged");
  good_word_a: assert property (take && legal |=> !illegal_o && !instr_ready_o)
    else $error("class word refused");
  single_word_a: assert property (take && legal && !instr_string_i && op != 5'h02 |-> ##2 done_o)
    else $error("one-word op not done in two cycles");
  lookup_strobe_a: assert property (take && legal && op == 5'h02 |-> ##2 pm_rd_o)
    else $error("lookup read missing");
  // applies to every lookup read, single-word and later string words alike
  dp_inc_a: assert property (pm_rd_o |-> ##[1:3] data_pointer_reg_o == pm_addr_o + 16'h0001)
    else $error("data pointer not advanced");
  clear_flags_a: assert property (take && legal && op == 5'h03 && !instr_string_i |-> ##2 zero_o && !carry_o)
    else $error("clear left wrong flags");
  done_pulse_a: assert property (done_o |-> instr_ready_o ##1 !done_o)
    else $error("done not a lone pulse with ready");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
  cover property (take && legal && instr_string_i);
  cover property (illegal_o);
  cover property (pm_rd_o);
endmodule // acc_ref_checker

bind acc_ref_exec acc_ref_checker #(.DW(DW)) u_acc_ref_checker (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_string_i(instr_string_i), .instr_ready_o(instr_ready_o),
  .done_o(done_o), .illegal_o(illegal_o), .pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o), .carry_o(carry_o),
  .zero_o(zero_o), .data_pointer_reg_o(data_pointer_reg_o), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

/* File: accumulator_reference_ops_tb_top.sv */
// self-checking bench for the accumulator-reference executor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module accumulator_reference_ops_tb_top;
  logic ref_clk_i = 0, sys_rst_i = 1, instr_valid_i = 0, instr_string_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [16:0] instr_i = 0;
  logic [15:0] pm_data_i = 0, reg_wdata_i = 0;
  logic [7:0] reg_addr_i = 0;
  wire instr_ready_o, done_o, illegal_o, pm_rd_o, carry_o, zero_o, sign_o, ovf_o;
  wire [15:0] pm_addr_o, data_pointer_reg_o, reg_rdata_o;
  int n_mismatch = 0, num_checks = 0;
  typedef struct packed {logic [4:0] op; logic sw; logic ds; logic [15:0] a; logic [15:0] b; logic [15:0] r;
    logic c;} row_t;
  // op, swap, dest, accumulator, offset accumulator, result, carry
  row_t rows [12] = '{
    '{5'h00, 1'h1, 1'h0, 16'h0001, 16'h0000, 16'hFFFF, 1'h0},
    '{5'h00, 1'h0, 1'h1, 16'h0000, 16'h0002, 16'hFFFE, 1'h0},
    '{5'h01, 1'h1, 1'h0, 16'h00F0, 16'h0000, 16'hFF0F, 1'h0},
    '{5'h01, 1'h0, 1'h0, 16'h0000, 16'h1234, 16'hEDCB, 1'h0},
    '{5'h03, 1'h0, 1'h1, 16'h1111, 16'h2222, 16'h0000, 1'h0},
    '{5'h04, 1'h0, 1'h0, 16'h0005, 16'h0003, 16'h0002, 1'h1},
    '{5'h04, 1'h1, 1'h1, 16'h0005, 16'h0003, 16'hFFFE, 1'h0},
    '{5'h05, 1'h0, 1'h0, 16'hFFFF, 16'h0001, 16'h0000, 1'h1},
    '{5'h06, 1'h0, 1'h1, 16'h8001, 16'h0000, 16'h0002, 1'h1},
    '{5'h06, 1'h1, 1'h0, 16'h0000, 16'h4000, 16'h8000, 1'h0},
    '{5'h07, 1'h1, 1'h0, 16'h0000, 16'h1234, 16'h1234, 1'h0},
    '{5'h07, 1'h0, 1'h1, 16'hABCD, 16'h0000, 16'hABCD, 1'h0}};
  logic [16:0] bad [3] = '{17'h1C004, 17'h1C040, 17'h0C000};

  acc_ref_exec u_acc_ref_exec (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_string_i(instr_string_i), .instr_ready_o(instr_ready_o), .done_o(done_o),
    .illegal_o(illegal_o), .pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .carry_o(carry_o),
    .zero_o(zero_o), .sign_o(sign_o), .ovf_o(ovf_o), .data_pointer_reg_o(data_pointer_reg_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));

  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // program memory answers from the registered address
  always @(posedge ref_clk_i) pm_data_i <= pm_addr_o ^ 16'h5A5A;

  function automatic [16:0] mk(input [4:0] op, input [3:0] pp, input sw, input ds);
    mk = {5'h1C, pp, op, 1'h0, sw, ds};
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [15:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input [7:0] a, input [15:0] e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 0;
    #1 `CHK("rdata", e, reg_rdata_o)
  endtask
  // returns in the cycle that shows done or illegal
  task automatic issue(input [16:0] w, input s);
    bit hit;
    hit = 0;
    @(posedge ref_clk_i);
    instr_valid_i <= 1;
    instr_i <= w;
    instr_string_i <= s;
    @(posedge ref_clk_i);
    instr_valid_i <= 0;
    for (int i = 0; i < 40 && !hit; i++)
    begin
      #1 hit = done_o | illegal_o;
      if (!hit) @(posedge ref_clk_i);
    end
    if (!hit)
    begin
      n_mismatch++;
      give_verdict;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    #1 `CHK("ready", 1'h1, instr_ready_o)
    `CHK("data_ptr", 16'h0000, data_pointer_reg_o)
    rd(8'h00, 16'h0000);
    rd(8'h02, 16'h0000);
    foreach (rows[k])
    begin
      wr(8'h20, rows[k].a);
      wr(8'h30, rows[k].b);
      issue(mk(rows[k].op, 4'h0, rows[k].sw, rows[k].ds), 0);
      `CHK("carry", rows[k].c, carry_o)
      `CHK("zero", rows[k].r == 16'h0000, zero_o)
      `CHK("sign", rows[k].r[15], sign_o)
      rd(rows[k].ds ? 8'h30 : 8'h20, rows[k].r);
    end
    // lookup through the accumulator address
    wr(8'h20, 16'h0100);
    issue(mk(5'h02, 4'h0, 1'h0, 1'h1), 0);
    `CHK("data_ptr", 16'h0101, data_pointer_reg_o)
    rd(8'h09, 16'h0101);
    rd(8'h30, 16'h0100 ^ 16'h5A5A);
    // three-word clear through pointer one, premodified upward
    wr(8'h05, 16'h0004);
    wr(8'h00, 16'h0001);
    for (int i = 0; i < 5; i++) wr(8'h24 + 8'(i), 16'h00FF);
    issue(mk(5'h03, 4'h5, 1'h0, 1'h0), 1);
    rd(8'h05, 16'h0005);
    for (int i = 0; i < 5; i++) rd(8'h24 + 8'(i), (i == 0 || i == 4) ? 16'h00FF : 16'h0000);
    // single clear through pointer one, premodified downward
    issue(mk(5'h03, 4'h9, 1'h0, 1'h0), 0);
    rd(8'h05, 16'h0004);
    rd(8'h24, 16'h0000);
    // marked copy runs once and chains the earlier zero flag
    wr(8'h01, 16'h0080);
    wr(8'h20, 16'h0001);
    wr(8'h21, 16'h0077);
    wr(8'h30, 16'h0000);
    issue(mk(5'h05, 4'h0, 1'h0, 1'h0), 0);
    issue(mk(5'h07, 4'h0, 1'h1, 1'h0), 1);
    `CHK("zero", 1'h0, zero_o)
    rd(8'h20, 16'h0000);
    rd(8'h21, 16'h0077);
    // signed overflow on add shows in the status word
    wr(8'h20, 16'h7FFF);
    wr(8'h30, 16'h0001);
    issue(mk(5'h05, 4'h0, 1'h0, 1'h0), 0);
    `CHK("ovf", 1'h1, ovf_o)
    rd(8'h08, 16'h000C);
    foreach (bad[k])
    begin
      issue(bad[k], 0);
      `CHK("illegal", 1'h1, illegal_o)
    end
    rd(8'h04, 16'h0000);
    give_verdict;
  end
endmodule // accumulator_reference_ops_tb_top
